// ---- hw/acp_consts.svh ----
// Purpose: timing counts, edge numbers and field positions of the port
// Assumes: included by the port design file by bare name
// Notes: definitions only
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// ==========================================================================
// frame edges
`define ACP_FRAME_BITS 5'h10
`define ACP_LAST_FALL 5'h0F
`define ACP_TRACK_RISE 5'h0E
`define ACP_CTRL_RISE 5'h0F
`define ACP_RANGE_FALL 5'h0B
// ==========================================================================
// input word layout
`define ACP_SEL_CTRL 2'h0
`define ACP_SEL_RANGE 2'h1
`define ACP_PM_HI 4'h9
`define ACP_PM_LO 4'h8
`define ACP_CTRL_RST 12'h000
`define ACP_RANGE_RST 8'h00
// ==========================================================================
// power-up times
`define ACP_CLK_HZ 20000000
`define ACP_STBY_NS 750
`define ACP_SHDN_US 500
`define ACP_STBY_CYC ((`ACP_STBY_NS * (`ACP_CLK_HZ / 1000000) + 999) / 1000)
`define ACP_SHDN_CYC (`ACP_SHDN_US * (`ACP_CLK_HZ / 1000000))
`endif

// ---- hw/acp_pkg.sv ----
// Purpose: types shared by the serial conversion port
// Assumes: nothing
// Notes: power modes follow the two mode bits of the control word
package acp_pkg;
  typedef enum logic [1:0] {
    ACP_PM_NORMAL = 2'b00,
    ACP_PM_AUTO_STBY = 2'b01,
    ACP_PM_AUTO_SHDN = 2'b10,
    ACP_PM_FULL_SHDN = 2'b11
  } acp_pm_e;
  typedef logic [13:0] acp_result_t;
endpackage : acp_pkg

// ---- hw/acp_port.sv ----
// Purpose: serial conversion port of a two-channel 12-bit plus sign converter
// Assumes: all link input pins are asynchronous to clock_in and are synchronised
// Notes: results from the converter core queue in a FIFO ahead of the link
//
// Behaviour
// RL1 - chip select falling freezes the sample and drives the output line
// RL2 - a conversion takes sixteen serial clocks; host must supply all
// RL3 - sampling returns to track on the fourteenth rising clock edge
// RL4 - output line released on the sixteenth falling clock edge
// RL5 - early chip select rise aborts and releases output; late writes stay
// RL6 - each input bit is captured on a falling clock edge
// RL7 - first three input bits, msb first, select the addressed register
// RL8 - control register loads on the fifteenth rising clock edge
// RL9 - range register loads on the eleventh falling clock edge
// RL10 - output word: two zeros, channel, sign, twelve magnitude bits
// RL11 - channel bit names the input channel of the result
// RL12 - first zero at chip select fall, second at first falling edge
// RL13 - host drives chip select from its frame sync, one per word
// RL14 - host samples output on falling edges, msb first
// RL15 - host sends next control word in the frame it reads a result
// RL16 - host spaces conversion starts by whole clock periods
// RL17 - register written only when the leading write bit is set
// RL18 - mode bits: normal, auto standby, auto shutdown, full shutdown
// RL19 - auto modes power up on chip select rise; 750 ns or 500 us
// RL20 - host waits the idle gap before the next chip select fall
// RL21 - chip select high: output released, clock and input ignored

`include "acp_consts.svh"

// ==========================================================================
// result queue
module acp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clock_in, // system clock
  input wire logic rstn_in, // async reset, active low
  input wire logic in_valid_in, // write request
  input wire logic [WIDTH-1:0] in_data_in, // write word
  output logic in_ready_out, // space available, registered
  output logic out_valid_out, // word available
  output logic [WIDTH-1:0] out_data_out, // head word
  input wire logic out_ready_in // read request
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
      in_ready_out <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_out <= (next_count != (AW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule : acp_fifo

// ==========================================================================
// serial port
module acp_port #(
  parameter int SHDN_CYC = `ACP_SHDN_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_in, // system clock, 20 MHz
  input wire logic rstn_in, // async reset, active low
  input wire logic cs_n_in, // chip select pin, active low
  input wire logic sclk_in, // serial clock pin
  input wire logic din_in, // serial data in pin
  output logic dout_out, // serial data out
  output logic dout_oe_out, // serial data out enable
  input wire logic core_valid_in, // converter result valid
  input wire acp_pkg::acp_result_t core_data_in, // {chan, sign, mag}
  output logic core_ready_out, // result queue can accept
  output logic hold_out, // sample stage held, 1 = hold
  output logic [11:0] ctrl_out, // control register
  output logic [7:0] range_out, // range register
  output logic powered_up_out // converter fully powered
);
  import acp_pkg::*;

  localparam int STBY_CYC = `ACP_STBY_CYC;

  logic cs_s1, cs_s2, cs_s3;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic din_s1, din_s2;
  logic cs_fall, cs_rise, sclk_fall, sclk_rise;
  logic active;
  logic [4:0] fall_cnt;
  logic [4:0] rise_cnt;
  logic [15:0] tx;
  logic [15:0] rx;
  logic q_valid;
  acp_result_t q_data;
  acp_result_t last_result;
  logic ctrl_hit, range_hit, rise15;
  acp_pm_e pm;
  acp_pm_e eff_pm;
  logic asleep;
  logic [13:0] wake_cnt;

  function automatic logic sel_hit(input logic wr, input logic [1:0] sel,
                                   input logic [1:0] target);
    sel_hit = wr && (sel == target);
  endfunction : sel_hit

  // ========================================================================
  // synchronisers and edge detection
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h7;
      {din_s1, din_s2} <= 2'h0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {cs_n_in, cs_s1, cs_s2};
      {sclk_s1, sclk_s2, sclk_s3} <= {sclk_in, sclk_s1, sclk_s2};
      {din_s1, din_s2} <= {din_in, din_s1};
    end
  end

  assign cs_fall = !cs_s2 && cs_s3;
  assign cs_rise = cs_s2 && !cs_s3;
  // clock and data ignored outside a frame
  assign sclk_fall = active && !sclk_s2 && sclk_s3; // RL21
  assign sclk_rise = active && sclk_s2 && !sclk_s3; // RL21

  // ========================================================================
  // result queue
  acp_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .in_valid_in(core_valid_in),
    .in_data_in(core_data_in),
    .in_ready_out(core_ready_out),
    .out_valid_out(q_valid),
    .out_data_out(q_data),
    .out_ready_in(cs_fall)
  );

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_result <= '0;
    end else if (cs_fall && q_valid) begin
      last_result <= q_data;
    end
  end

  // ========================================================================
  // frame counters
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      active <= 1'b0;
      fall_cnt <= '0;
      rise_cnt <= '0;
    end else if (cs_fall) begin
      active <= 1'b1;
      fall_cnt <= '0;
      rise_cnt <= '0;
    end else if (cs_rise) begin
      active <= 1'b0; // RL5
    end else begin
      if (sclk_fall && fall_cnt != `ACP_FRAME_BITS) begin
        fall_cnt <= fall_cnt + 1'b1; // RL2
      end
      if (sclk_rise && rise_cnt != `ACP_FRAME_BITS) begin
        rise_cnt <= rise_cnt + 1'b1;
      end
    end
  end

  // ========================================================================
  // output shifter
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx <= '0;
      dout_out <= 1'b0;
      dout_oe_out <= 1'b0;
    end else if (cs_fall) begin
      // zeros, channel, sign, magnitude; a stale result if queue is empty
      tx <= {2'h0, (q_valid ? q_data : last_result)}; // RL10 RL11
      dout_out <= 1'b0; // RL12
      dout_oe_out <= 1'b1; // RL1
    end else if (cs_rise) begin
      dout_oe_out <= 1'b0; // RL5 RL21
    end else if (sclk_fall) begin
      tx <= {tx[14:0], 1'b0};
      dout_out <= tx[14]; // RL12
      if (fall_cnt == `ACP_LAST_FALL) begin
        dout_oe_out <= 1'b0; // RL4
      end
    end
  end

  // ========================================================================
  // track and hold
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_out <= 1'b0;
    end else if (cs_fall) begin
      hold_out <= 1'b1; // RL1
    end else if (cs_rise) begin
      hold_out <= 1'b0; // RL5 RL19
    end else if (sclk_rise && rise_cnt == `ACP_TRACK_RISE - 5'h01) begin
      hold_out <= 1'b0; // RL3
    end
  end

  // ========================================================================
  // input shifter and register writes
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx <= '0;
    end else if (cs_fall) begin
      rx <= '0;
    end else if (sclk_fall) begin
      rx <= {rx[14:0], din_s2}; // RL6
    end
  end

  // header: write bit then two select bits, msb first
  assign range_hit = sclk_fall && fall_cnt == `ACP_RANGE_FALL - 5'h01
                     && sel_hit(rx[9], rx[8:7], `ACP_SEL_RANGE); // RL7 RL17
  assign rise15 = sclk_rise && rise_cnt == `ACP_CTRL_RISE - 5'h01;
  assign ctrl_hit = rise15
                    && sel_hit(rx[14], rx[13:12], `ACP_SEL_CTRL); // RL7 RL17

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_out <= `ACP_CTRL_RST;
      range_out <= `ACP_RANGE_RST;
    end else begin
      if (ctrl_hit) begin
        ctrl_out <= rx[11:0]; // RL8
      end
      if (range_hit) begin
        range_out <= {rx[6:0], din_s2}; // RL9
      end
    end
  end

  // ========================================================================
  // power management
  assign pm = acp_pm_e'({ctrl_out[`ACP_PM_HI], ctrl_out[`ACP_PM_LO]});
  assign eff_pm = ctrl_hit ? acp_pm_e'({rx[`ACP_PM_HI], rx[`ACP_PM_LO]})
                           : pm; // RL18

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      asleep <= 1'b0;
      wake_cnt <= '0;
    end else if (rise15) begin
      asleep <= (eff_pm != ACP_PM_NORMAL); // RL18
      if (asleep && eff_pm == ACP_PM_NORMAL) begin
        wake_cnt <= 14'(SHDN_CYC);
      end
    end else if (cs_rise && asleep && pm != ACP_PM_FULL_SHDN) begin
      asleep <= 1'b0;
      wake_cnt <= (pm == ACP_PM_AUTO_STBY) ? 14'(STBY_CYC)
                                           : 14'(SHDN_CYC); // RL19
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      powered_up_out <= 1'b0;
    end else begin
      powered_up_out <= !asleep && wake_cnt == '0; // RL19
    end
  end

  // ========================================================================
  // checks
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  AST_CS_FALL: assert property (cs_fall |=> dout_oe_out && hold_out // RL1
    && !dout_out) else $error("frame start did not hold and drive");
  AST_TRACK14: assert property ( // RL3
    sclk_rise && rise_cnt == 5'h0D && !cs_rise |=> !hold_out)
    else $error("no track at rising edge 14");
  AST_OE_OFF16: assert property ( // RL4
    sclk_fall && fall_cnt == 5'h0F |=> !dout_oe_out)
    else $error("output still driven after falling edge 16");
  AST_ABORT: assert property ( // RL5
    cs_rise |=> !dout_oe_out && !hold_out && !active)
    else $error("early chip select rise did not abort");
  AST_CAPTURE: assert property ( // RL6
    sclk_fall |=> rx[0] == $past(din_s2))
    else $error("input bit not captured");
  AST_CTRL15: assert property ( // RL8
    ctrl_hit |=> ctrl_out == $past(rx[11:0]))
    else $error("control register not loaded");
  AST_RANGE11: assert property ( // RL9
    range_hit |=> range_out == {$past(rx[6:0]), $past(din_s2)})
    else $error("range register not loaded");
  AST_NO_WRITE: assert property ( // RL17
    rise15 && !rx[14] |=> $stable(ctrl_out))
    else $error("control written without write bit");
  AST_ZERO2: assert property ( // RL12
    sclk_fall && fall_cnt == 5'h00 |=> !dout_out)
    else $error("second leading bit not zero");
  AST_IDLE: assert property ( // RL21
    !active && !cs_fall |=> !dout_oe_out)
    else $error("output driven outside a frame");
  AST_STBY: assert property ( // RL19
    cs_rise && asleep && pm == ACP_PM_AUTO_STBY
    |=> !powered_up_out [*8])
    else $error("standby wake too short");

  COV_FULL: cover property (sclk_fall && fall_cnt == 5'h0F);
  COV_CTRL: cover property (ctrl_hit);
  COV_ABORT: cover property (cs_rise && fall_cnt != 5'h10 && active);
  COV_WAKE: cover property (cs_rise && asleep);
endmodule : acp_port

// ---- dv/acp_host_model.sv ----
// Purpose: host serial port model driving the conversion port link
// Assumes: 400 ns serial clock; the bench starts every frame
// Notes: a released data line reads back as the inverse of its last level
module acp_host_model (
  input wire logic dout_in, // device data out
  input wire logic dout_oe_in, // device data out enable
  input wire logic hold_in, // device hold state
  input wire logic pwr_in, // device powered flag
  output logic cs_n_out, // chip select, active low
  output logic sclk_out, // serial clock, idles high
  output logic din_out // serial data to device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  logic line;
  // ==========================================================================
  // wire level seen by the host
  always @(dout_in or dout_oe_in) if (dout_oe_in) last = dout_in;
  assign line = dout_oe_in ? dout_in : ~last;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    din_out = 1'b0;
  end
  // ==========================================================================
  // one frame of n clocks; obs = {pwr, oe after end, hold at fall 15, start}
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] rx, output logic [3:0] obs);
    rx = 16'h0000;
    obs = 4'h0;
    cs_n_out = 1'b0;
    din_out = w[15];
    #400;
    for (int i = 1; i <= n; i++) begin
      sclk_out = 1'b0;
      rx[16-i] = line;
      if (i == 1) obs[0] = hold_in & dout_oe_in;
      if (i == 15) obs[1] = hold_in;
      #200;
      sclk_out = 1'b1;
      if (i < 16) din_out = w[15-i];
      #200;
    end
    #100;
    obs[3] = pwr_in;
    cs_n_out = 1'b1;
    din_out = ~din_out;
    #300;
    obs[2] = dout_oe_in;
    #400;
  endtask : xfer
  // ==========================================================================
  // clock and data activity while deselected
  task automatic noise(input logic [31:0] pat);
    for (int i = 0; i < 16; i++) begin
      sclk_out = pat[2*i];
      din_out = pat[2*i+1];
      #130;
    end
    sclk_out = 1'b1;
    #400;
  endtask : noise
endmodule : acp_host_model

// ---- dv/test_adc_serial_conversion_port.sv ----
// Purpose: self-checking bench of the serial conversion port
// Assumes: host model owns the link pins
// Notes: shutdown wake shortened through SHDN_CYC
module test_adc_serial_conversion_port;
  timeunit 1ns;
  timeprecision 1ns;
  import acp_pkg::*;
  localparam int SHDN = 20;
  localparam logic [1:0] SEL_T [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h1};
  localparam int LEN_T [5] = '{16, 16, 14, 11, 10};
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic core_valid = 1'b0;
  acp_result_t core_data = '0;
  logic cs_n, sclk, din, dout, dout_oe, core_ready, hold, pwr;
  logic [11:0] ctrl;
  logic [7:0] range;
  logic [15:0] rx;
  logic [3:0] obs;
  logic [31:0] seed = 32'h00003269;
  int err_total = 0;
  int cmp_count = 0;
  always #25 clock_in = ~clock_in;
  acp_port #(.SHDN_CYC(SHDN), .FIFO_DEPTH(8)) i_dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .din_in(din), .dout_out(dout),
    .dout_oe_out(dout_oe), .core_valid_in(core_valid),
    .core_data_in(core_data), .core_ready_out(core_ready),
    .hold_out(hold), .ctrl_out(ctrl), .range_out(range),
    .powered_up_out(pwr));
  acp_host_model i_host (
    .dout_in(dout), .dout_oe_in(dout_oe), .hold_in(hold), .pwr_in(pwr),
    .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [15:0] exp_word(input acp_result_t r);
    return {2'b00, r};
  endfunction : exp_word
  task automatic chk(input string name, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  // ==========================================================================
  // main sequence
  initial begin
    acp_result_t q[$];
    acp_result_t last;
    logic [31:0] r;
    logic [11:0] d;
    logic [11:0] ec;
    logic [7:0] er;
    ec = 12'h000;
    er = 8'h00;
    repeat (6) @(negedge clock_in);
    chk("reset ctrl", 16'h0000, {4'h0, ctrl});
    chk("reset range", 16'h0000, {8'h00, range});
    chk("reset oe ready pwr", 16'h0000, {13'h0, dout_oe, core_ready, pwr});
    rstn_in = 1'b1;
    repeat (3) @(negedge clock_in);
    chk("ready pwr", 16'h0003, {14'h0, core_ready, pwr});
    for (int i = 0; i < 8; i++) begin
      core_valid = 1'b1;
      core_data = acp_result_t'(xs());
      q.push_back(core_data);
      @(negedge clock_in);
    end
    core_valid = 1'b0;
    repeat (2) @(negedge clock_in);
    chk("queue full", 16'h0000, {15'h0, core_ready});
    core_valid = 1'b1;
    core_data = 14'h3FFF;
    repeat (2) @(negedge clock_in);
    core_valid = 1'b0;
    for (int i = 0; i < 9; i++) begin
      r = xs();
      i_host.noise(r);
      i_host.xfer({1'b0, r[14:0]}, 16, rx, obs);
      if (q.size() > 0) last = q.pop_front();
      chk("rx word", exp_word(last), rx);
      chk("frame obs", 16'h0009, {12'h000, obs});
      chk("ctrl keep", {4'h0, ec}, {4'h0, ctrl});
      chk("range keep", {8'h00, er}, {8'h00, range});
      if (i == 0) chk("ready again", 16'h0001, {15'h0, core_ready});
    end
    for (int k = 0; k < 5; k++) begin
      r = xs();
      d = {r[11:10], 2'b00, r[7:0]};
      i_host.xfer({1'b1, SEL_T[k], d, 1'b0}, LEN_T[k], rx, obs);
      if (LEN_T[k] > (SEL_T[k] == 2'h0 ? 14 : 10)) begin
        if (SEL_T[k] == 2'h0) ec = d;
        else er = d[11:4];
      end
      chk("write ctrl", {4'h0, ec}, {4'h0, ctrl});
      chk("write range", {8'h00, er}, {8'h00, range});
      chk("write obs", 16'h0009, {12'h000, obs});
    end
    for (int m = 0; m < 5; m++) begin
      r = xs();
      d = {r[11:10], m[1:0] & {2{m < 4}}, r[7:0]};
      i_host.xfer({1'b1, 2'h0, d, 1'b0}, 16, rx, obs);
      ec = d;
      chk("mode ctrl", {4'h0, ec}, {4'h0, ctrl});
      // leaving full shutdown still needs the wake time after the frame
      chk("mode obs", {12'h000, m == 0, 3'b001}, {12'h000, obs});
      repeat (SHDN + 20) @(negedge clock_in);
      chk("wake", {15'h0, m != 3}, {15'h0, pwr});
    end
    report_and_stop();
  end
endmodule : test_adc_serial_conversion_port
